// ---- dv/lcg_neighbour_model.sv ----
// model of the neighbouring cells and routing that feed the cell group
`timescale 1ns/1ps
module lcg_neighbour_model (
    input  wire logic       clk_sys,
    input  wire logic [3:0] glob_req,
    input  wire logic [3:0] io_req,
    input  wire logic       casc_req,
    output logic [3:0]      global_in,
    output logic [3:0]      io_in,
    output logic            cascade_in
);
    // ==========================================================================
    // registered neighbour: levels change only at clock edges
    always_ff @(posedge clk_sys) begin
        global_in  <= glob_req;
        io_in      <= io_req;
        cascade_in <= casc_req;
    end
endmodule : lcg_neighbour_model

// ---- dv/testbench.sv ----
// self-checking bench for the logic cell group
`timescale 1ns/1ps
`include "lcg_defs.svh"
module testbench;
    import lcg_pkg::*;
    logic        clk_sys = 1'b0, reset = 1'b1, chip_reset_in = 1'b0, casc_req = 1'b0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, cell_ena_in = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, cell_data_in = 32'h0;
    logic [3:0]  glob_req = 4'h0, io_req = 4'h0, global_in, io_in, wstrb = 4'hF;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        cascade_in, cascade_out, global_drive_out;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp, ded_clk_in = 2'h0;
    logic [31:0] s_axi_rdata, rdat;
    logic [7:0]  cell_local_out, cell_fabric_out;
    int          num_errors = 0, check_count = 0;

    always #2.5 clk_sys = ~clk_sys;

    lcg_cell_group #(.GROUP_NUM(3), .ROW_HALF(18)) DUT (.clk_sys(clk_sys), .reset(reset),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .ded_clk_in(ded_clk_in), .global_in(global_in), .io_in(io_in),
        .chip_reset_in(chip_reset_in), .cell_data_in(cell_data_in), .cell_ena_in(cell_ena_in),
        .cascade_in(cascade_in), .cascade_out(cascade_out), .cell_local_out(cell_local_out),
        .cell_fabric_out(cell_fabric_out), .global_drive_out(global_drive_out));

    lcg_neighbour_model u_nbr (.clk_sys(clk_sys), .glob_req(glob_req), .io_req(io_req),
        .casc_req(casc_req), .global_in(global_in), .io_in(io_in), .cascade_in(cascade_in));

    // ==========================================================================
    // bus and compare tasks
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w, awt, wt, b;
        aw = 1'b1;
        w = 1'b1;
        s_axi_awaddr <= a; s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
        while (aw || w) begin
            @(negedge clk_sys);
            awt = aw && s_axi_awready;
            wt = w && s_axi_wready;
            @(posedge clk_sys);
            if (awt) begin aw = 1'b0; s_axi_awvalid <= 1'b0; end
            if (wt) begin w = 1'b0; s_axi_wvalid <= 1'b0; end
        end
        do begin
            @(negedge clk_sys);
            b = s_axi_bvalid;
            resp = s_axi_bresp;
            @(posedge clk_sys);
        end while (b !== 1'b1);
        s_axi_bready <= 1'b0;
        @(posedge clk_sys);
        chk("bresp", {30'h0, resp}, {30'h0, `LCG_RESP_OKAY});
    endtask : wr

    task automatic rd(input logic [7:0] a);
        logic v;
        s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
        do begin @(negedge clk_sys); v = s_axi_arready; @(posedge clk_sys); end while (v !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do begin
            @(negedge clk_sys);
            v = s_axi_rvalid;
            rdat = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge clk_sys);
        end while (v !== 1'b1);
        s_axi_rready <= 1'b0;
        @(posedge clk_sys);
    endtask : rd

    task automatic w8;
        repeat (8) @(posedge clk_sys);
    endtask : w8

    task automatic q_is(input logic [7:0] e);
        w8();
        rd(`LCG_OFF_STATUS);
        chk("flop q", {24'h0, rdat[`LCG_STAT_Q]}, {24'h0, e});
    endtask : q_is

    task automatic tick;
        glob_req[0] <= 1'b1; w8(); glob_req[0] <= 1'b0; w8();
    endtask : tick

    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : complete_run

    // ==========================================================================
    // tests
    initial begin
        #100000;
        num_errors++;
        complete_run();
    end

    initial begin
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        rd(`LCG_OFF_MODE); chk("mode reset", rdat, `LCG_MODE_RST);
        rd(`LCG_OFF_CTRL_SEL); chk("sel reset", rdat, `LCG_SEL_RST);
        rd(8'h40); chk("unmapped resp", {30'h0, resp}, {30'h0, `LCG_RESP_SLVERR});
        wstrb <= 4'h2; wr(`LCG_OFF_CELL_CFG, 32'hFFFF_FFFF); wstrb <= 4'hF;
        rd(`LCG_OFF_CELL_CFG); chk("byte strobe", rdat, 32'h0000_FF00);
        $display("test registers done");
        wr(`LCG_OFF_LUT0, 32'h6996);
        for (int i = 0; i < 16; i++) begin
            cell_data_in[3:0] <= i[3:0];
            repeat (3) @(posedge clk_sys);
            chk("lut fabric", {31'h0, cell_fabric_out[0]}, 32'h6996 >> i & 32'h1);
            chk("lut local", {31'h0, cell_local_out[0]}, 32'h6996 >> i & 32'h1);
        end
        $display("test lookup done");
        for (int i = 0; i < 8; i++) wr(8'(4 * i), 32'h8000);
        wr(`LCG_OFF_CELL_CFG, 32'h0000_00FF);
        cell_data_in <= 32'hFFFF_FFFF; casc_req <= 1'b1; w8();
        chk("and chain", {31'h0, cascade_out}, 32'h1);
        cell_data_in[31] <= 1'b0; w8();
        chk("and last input", {31'h0, cascade_out}, 32'h0);
        cell_data_in[31] <= 1'b1; casc_req <= 1'b0; w8();
        chk("chain from group", {31'h0, cascade_out}, 32'h0);
        wr(`LCG_OFF_CELL_CFG, 32'h0000_FFFF);
        cell_data_in <= 32'h0000_F000; w8();
        chk("or chain one", {31'h0, cascade_out}, 32'h1);
        cell_data_in <= 32'h0; w8();
        chk("or chain none", {31'h0, cascade_out}, 32'h0);
        $display("test cascade done");
        wr(`LCG_OFF_CTRL_SEL, 32'h0084_8002);
        wr(`LCG_OFF_CELL_CFG, 32'h00FF_0000);
        cell_data_in <= 32'hFFFF_FFFF; tick(); q_is(8'h00);
        cell_ena_in <= 8'hFF; tick(); q_is(8'hFF);
        chk("global drive high", {31'h0, global_drive_out}, 32'h1);
        cell_data_in <= 32'h0; wr(`LCG_OFF_CTRL_SEL, 32'h0084_8082); wr(`LCG_OFF_CELL_CFG, 32'hFFFF_0000);
        ded_clk_in[0] <= 1'b1; q_is(8'h00);
        chk("global drive low", {31'h0, global_drive_out}, 32'h0);
        cell_data_in <= 32'hFFFF_FFFF; wr(`LCG_OFF_CELL_CFG, 32'h00FF_0000); tick(); q_is(8'hFF);
        wr(`LCG_OFF_MODE, 32'h2);
        glob_req[1] <= 1'b1; q_is(8'h00);
        glob_req[1] <= 1'b0;
        wr(`LCG_OFF_MODE, 32'h4);
        glob_req[1] <= 1'b1; q_is(8'hFF);
        glob_req[1] <= 1'b0; io_req[0] <= 1'b1; q_is(8'h00);
        tick(); q_is(8'h00);
        io_req[0] <= 1'b0;
        wr(`LCG_OFF_MODE, 32'h44); q_is(8'hFF);
        wr(`LCG_OFF_MODE, 32'h4C); chip_reset_in <= 1'b1; q_is(8'h00);
        $display("test flip-flop done");
        complete_run();
    end
endmodule : testbench

// ---- hdl/lcg_cell_group.sv ----
// group of eight logic cells with shared control lines, cascade and register slave
`timescale 1ns/1ps
`include "lcg_defs.svh"
module lcg_cell_group #(
    parameter int GROUP_NUM = 1,
    parameter int ROW_HALF  = 18
) (
    input  wire logic                    clk_sys,
    input  wire logic                    reset,
    input  wire logic [`LCG_ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic [2:0]              s_axi_awprot,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [`LCG_ADDR_W-1:0]  s_axi_araddr,
    input  wire logic [2:0]              s_axi_arprot,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    input  wire logic [1:0]              ded_clk_in,
    input  wire logic [3:0]              global_in,
    input  wire logic [3:0]              io_in,
    input  wire logic                    chip_reset_in,
    input  wire logic [31:0]             cell_data_in,
    input  wire logic [7:0]              cell_ena_in,
    input  wire logic                    cascade_in,
    output logic                         cascade_out,
    output logic [7:0]                   cell_local_out,
    output logic [7:0]                   cell_fabric_out,
    output logic                         global_drive_out
);
    import lcg_pkg::*;

    localparam int  N_EXT       = 11;
    localparam bit  CASC_IN_OK  = (GROUP_NUM > 2) && (GROUP_NUM != ROW_HALF + 1) && (GROUP_NUM != ROW_HALF + 2);
    localparam bit  CASC_OUT_OK = (GROUP_NUM + 2 <= ROW_HALF) || (GROUP_NUM > ROW_HALF);

    // ==========================================================================
    // register slave
    logic [15:0]            lut_q [8];
    logic [31:0]            cfg_q;
    logic [31:0]            sel_q;
    logic [31:0]            mode_q;
    logic [`LCG_ADDR_W-1:0] awaddr_q;
    logic [31:0]            wdata_q;
    logic [3:0]             wstrb_q;
    logic                   aw_held_q;
    logic                   w_held_q;
    logic                   bvalid_q;
    logic [1:0]             bresp_q;
    logic                   rvalid_q;
    logic [31:0]            rdata_q;
    logic [1:0]             rresp_q;
    logic                   wr_fire;
    logic [5:0]             wr_word;
    logic [5:0]             rd_word;
    logic                   wr_lut;
    logic                   wr_cfg;
    logic                   wr_sel;
    logic                   wr_mode;
    logic                   wr_ok;
    logic [31:0]            rd_val;
    logic                   rd_ok;
    logic [31:0]            status;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready  = !w_held_q && !bvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign wr_fire       = aw_held_q && w_held_q && !bvalid_q;
    assign wr_word       = awaddr_q[`LCG_ADDR_W-1:`LCG_WORD_LSB];
    assign rd_word       = s_axi_araddr[`LCG_ADDR_W-1:`LCG_WORD_LSB];

    always_comb begin
        wr_lut = 1'b0;
        wr_cfg = 1'b0;
        wr_sel = 1'b0;
        wr_mode = 1'b0;
        if (awaddr_q < `LCG_OFF_CELL_CFG) begin
            wr_lut = 1'b1;
        end else if (awaddr_q[`LCG_ADDR_W-1:`LCG_WORD_LSB] == `LCG_OFF_CELL_CFG >> `LCG_WORD_LSB) begin
            wr_cfg = 1'b1;
        end else if (awaddr_q[`LCG_ADDR_W-1:`LCG_WORD_LSB] == `LCG_OFF_CTRL_SEL >> `LCG_WORD_LSB) begin
            wr_sel = 1'b1;
        end else if (awaddr_q[`LCG_ADDR_W-1:`LCG_WORD_LSB] == `LCG_OFF_MODE >> `LCG_WORD_LSB) begin
            wr_mode = 1'b1;
        end
    end
    assign wr_ok = wr_lut || wr_cfg || wr_sel || wr_mode;

    always_comb begin
        rd_val = 32'h0000_0000;
        rd_ok  = 1'b1;
        if (s_axi_araddr < `LCG_OFF_CELL_CFG) begin
            rd_val = {16'h0000, lut_q[rd_word[2:0]]};
        end else if (rd_word == `LCG_OFF_CELL_CFG >> `LCG_WORD_LSB) begin
            rd_val = cfg_q;
        end else if (rd_word == `LCG_OFF_CTRL_SEL >> `LCG_WORD_LSB) begin
            rd_val = sel_q;
        end else if (rd_word == `LCG_OFF_MODE >> `LCG_WORD_LSB) begin
            rd_val = mode_q;
        end else if (rd_word == `LCG_OFF_STATUS >> `LCG_WORD_LSB) begin
            rd_val = status;
        end else begin
            rd_ok = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            aw_held_q <= 1'b0;
            awaddr_q  <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            w_held_q <= 1'b0;
            wdata_q  <= 32'h0000_0000;
            wstrb_q  <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            bvalid_q <= 1'b0;
            bresp_q  <= `LCG_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_ok ? `LCG_RESP_OKAY : `LCG_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= `LCG_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_val;
            rresp_q  <= rd_ok ? `LCG_RESP_OKAY : `LCG_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            cfg_q  <= `LCG_CFG_RST;
            sel_q  <= `LCG_SEL_RST;
            mode_q <= `LCG_MODE_RST;
        end else if (wr_fire) begin
            cfg_q  <= wr_cfg ? merge(cfg_q, wdata_q, wstrb_q) : cfg_q;
            sel_q  <= wr_sel ? merge(sel_q, wdata_q, wstrb_q) : sel_q;
            mode_q <= wr_mode ? merge(mode_q, wdata_q, wstrb_q) : mode_q;
        end
    end

    // ==========================================================================
    // pin input filter: three stages, change taken when the last two agree
    logic [N_EXT-1:0] ext_raw;
    logic [N_EXT-1:0] ext_f;
    assign ext_raw = {chip_reset_in, io_in, global_in, ded_clk_in};

    for (genvar e = 0; e < N_EXT; e++) begin : g_sync
        logic [2:0] s_q;
        logic       f_q;
        always_ff @(posedge clk_sys or posedge reset) begin
            if (reset) begin
                s_q <= 3'h0;
                f_q <= 1'b0;
            end else begin
                s_q <= {s_q[1:0], ext_raw[e]};
                f_q <= (s_q[1] == s_q[2]) ? s_q[2] : f_q;
            end
        end
        assign ext_f[e] = f_q;
    end

    // ==========================================================================
    // shared control lines
    logic [3:0] line;
    logic [1:0] clk_prev_q;
    logic [1:0] clk_rise;
    logic [7:0] cell_out;
    logic [7:0] cell_q;
    logic [7:0] lut_out;
    logic [7:0] casc;
    logic       chip_rst;
    logic       clr_all;
    logic       pre_all;
    lcg_clr_mode_e clr_mode;

    for (genvar k = 0; k < 4; k++) begin : g_line
        lcg_ctrl_line #(.IS_CLOCK(k < 2)) u_line ( // RULE4
            .ded_clk   (ext_f[1:0]),
            .glob      (ext_f[5:2]),
            .io        (ext_f[9:6]),
            .local_sig (cell_out),
            .kind      (lcg_src_e'(sel_q[k*`LCG_SEL_W +: 4])),
            .idx       (sel_q[k*`LCG_SEL_W+4 +: 3]),
            .invert    (mode_q[4+k]),
            .line      (line[k])
        );
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            clk_prev_q <= 2'h0;
        end else begin
            clk_prev_q <= line[1:0];
        end
    end

    assign clk_rise = line[1:0] & ~clk_prev_q; // RULE15
    assign clr_mode = lcg_clr_mode_e'(mode_q[`LCG_MODE_CLR]);
    assign chip_rst = mode_q[`LCG_MODE_CHIP_EN] && ext_f[10];
    assign clr_all  = chip_rst || (clr_mode == LCG_MODE_CLR_ONLY && (line[2] || line[3])) // RULE12 RULE13
                   || (clr_mode == LCG_MODE_PRE_CLR && line[3]); // RULE14
    assign pre_all  = !chip_rst && clr_mode == LCG_MODE_PRE_CLR && line[2]; // RULE14

    // ==========================================================================
    // cells and cascade chain
    for (genvar i = 0; i < 8; i++) begin : g_cell
        logic        cin;
        logic [31:0] lut_wide;
        assign lut_wide = merge({16'h0000, lut_q[i]}, wdata_q, wstrb_q);
        if (i == 0) begin : g_first
            assign cin = CASC_IN_OK ? cascade_in : !cfg_q[8]; // RULE9 RULE10
        end else begin : g_next
            assign cin = casc[i-1];
        end
        always_ff @(posedge clk_sys or posedge reset) begin
            if (reset) begin
                lut_q[i] <= `LCG_LUT_RST;
            end else if (wr_fire && wr_lut && wr_word[2:0] == i) begin
                lut_q[i] <= lut_wide[15:0];
            end
        end
        lcg_logic_cell u_cell (
            .clk_sys  (clk_sys),
            .reset    (reset),
            .lut_mask (lut_q[i]),
            .data     (cell_data_in[i*4 +: 4]),
            .casc_in  (cin),
            .casc_en  (cfg_q[i]),
            .casc_or  (cfg_q[8+i]),
            .use_reg  (cfg_q[16+i]),
            .cap      (clk_rise[cfg_q[24+i]] && cell_ena_in[i]), // RULE2
            .clr      (clr_all),
            .pre      (pre_all),
            .lut_out  (lut_out[i]),
            .casc_out (casc[i]),
            .cell_out (cell_out[i]),
            .q        (cell_q[i])
        );
    end

    assign cascade_out = CASC_OUT_OK ? casc[7] : !cfg_q[15]; // RULE9 RULE10
    assign status = {12'h000, cell_out, line, cell_q};

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            cell_local_out   <= 8'h00;
            cell_fabric_out  <= 8'h00;
            global_drive_out <= 1'b0;
        end else begin
            cell_local_out   <= cell_out; // RULE11
            cell_fabric_out  <= cell_out; // RULE11
            global_drive_out <= cell_out[mode_q[`LCG_MODE_GDRV]]; // RULE6
        end
    end

    // ==========================================================================
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    a_lut_plain_out: assert property (!cfg_q[0] && !cfg_q[16] |-> cell_out[0] == lut_q[0][cell_data_in[3:0]]) // RULE1
        else $error("cell 0 output differs from its table");
    a_capture_on_ena: assert property (clk_rise[cfg_q[24]] && cell_ena_in[0] && !clr_all && !pre_all // RULE15
        |=> cell_q[0] == $past(casc[0])) else $error("cell 0 missed an enabled capture");
    a_hold_without_ena: assert property (!cell_ena_in[1] && !clr_all && !pre_all |=> $stable(cell_q[1])) // RULE2
        else $error("cell 1 changed without enable");
    a_clear_only_mode: assert property (clr_mode == LCG_MODE_CLR_ONLY && (line[2] || line[3]) |=> cell_q == 8'h00) // RULE13
        else $error("clear line did not clear");
    a_preset_first_line: assert property (!chip_rst && clr_mode == LCG_MODE_PRE_CLR && line[2] && !line[3] // RULE14
        |=> cell_q == 8'hFF) else $error("first line did not preset");
    a_chip_reset_wins: assert property (chip_rst |=> cell_q == 8'h00) // RULE12
        else $error("chip reset did not clear the cells");
    a_cascade_and_link: assert property (cfg_q[1] && !cfg_q[9] |-> casc[1] == (lut_out[1] & casc[0])) // RULE7
        else $error("cascade AND link wrong");
    a_cascade_or_link: assert property (cfg_q[2] && cfg_q[10] |-> casc[2] == (lut_out[2] | casc[1])) // RULE7
        else $error("cascade OR link wrong");
    a_chain_break: assert property (cfg_q[0] |-> casc[0] == (!CASC_IN_OK ? lut_out[0] // RULE9 RULE10
        : cfg_q[8] ? (lut_out[0] | cascade_in) : (lut_out[0] & cascade_in)))
        else $error("cascade crossed a break");
    a_both_routes: assert property (##1 cell_fabric_out == $past(cell_out) && cell_local_out == $past(cell_out)) // RULE11
        else $error("routing outputs disagree");
    a_write_answer: assert property (wr_fire |=> s_axi_bvalid [*1] ##0 !s_axi_awready)
        else $error("write not answered");

    c_full_chain: cover property (cfg_q[7:0] == 8'hFF && cascade_out);
    c_preset_seen: cover property (pre_all ##1 cell_q[0]);
    c_clear_seen: cover property (clr_all && cell_q != 8'h00);
    c_capture_seen: cover property (clk_rise[0] && cell_ena_in != 8'h00);
endmodule : lcg_cell_group

// ---- hdl/lcg_ctrl_line.sv ----
// one shared control line: source select and inversion
`timescale 1ns/1ps
module lcg_ctrl_line #(
    parameter bit IS_CLOCK = 1'b1
) (
    input  wire logic [1:0]        ded_clk,
    input  wire logic [3:0]        glob,
    input  wire logic [3:0]        io,
    input  wire logic [7:0]        local_sig,
    input  wire lcg_pkg::lcg_src_e kind,
    input  wire logic [2:0]        idx,
    input  wire logic              invert,
    output logic                   line
);
    import lcg_pkg::*;

    logic raw;

    // ==========================================================================
    // source select
    always_comb begin
        case (kind)
            LCG_SRC_DED:   raw = IS_CLOCK ? ded_clk[idx[0]] : 1'b0; // RULE5
            LCG_SRC_GLOB:  raw = glob[idx[1:0]];
            LCG_SRC_IO:    raw = io[idx[1:0]];
            LCG_SRC_LOCAL: raw = local_sig[idx]; // RULE6
            default:       raw = 1'b0;
        endcase
    end

    assign line = raw ^ invert; // RULE3
endmodule : lcg_ctrl_line

// ---- hdl/lcg_defs.svh ----
// constants for the logic cell group: register map, fields, reset values
//
// Function
// (RULE1) every cell holds a four-input lookup table that can produce any function of its four inputs.
// (RULE2) every cell holds one flip-flop whose capture is gated by a synchronous clock enable.
// (RULE3) the group has four shared control lines, each with its own inversion, visible to all eight cells.
// (RULE4) two of the control lines act as cell clocks and the other two as clear or preset controls.
// (RULE5) clock lines pick dedicated clocks, global, I/O or local signals; clear lines pick only global, I/O or local.
// (RULE6) any cell output can drive a control line through local routing and can also drive a global line.
// (RULE7) the cascade link joins a cell's table output with the previous cascade value by AND, or by OR via inversion.
// (RULE8) each cell added to a cascade chain widens the function by four inputs, giving 4n inputs for n cells.
// (RULE9) a chain longer than eight cells leaves the last cell and enters the first cell of the group two places on.
// (RULE10) a chain never crosses the middle of the row; it stops at group eighteen and a new one starts at nineteen.
// (RULE11) every cell output drives the local routing and the row and column routing at the same time.
// (RULE12) when enabled, the chip-wide reset overrides all other controls in every mode and clears every cell register.
// (RULE13) in clear-only mode either clear line clears the flip-flop and the preset path stays inactive.
// (RULE14) in preset-and-clear mode the first clear line loads a one from the fourth input tied high; the second clears.
// (RULE15) the flip-flop captures on the selected clock's rising edge only with enable high; clear and preset win.
`ifndef LCG_DEFS_SVH
`define LCG_DEFS_SVH

// ==========================================================================
// register map (byte addresses)
`define LCG_ADDR_W        8
`define LCG_OFF_LUT0      8'h00
`define LCG_OFF_CELL_CFG  8'h20
`define LCG_OFF_CTRL_SEL  8'h24
`define LCG_OFF_MODE      8'h28
`define LCG_OFF_STATUS    8'h2C
`define LCG_WORD_LSB      2

// ==========================================================================
// fields
`define LCG_CFG_CASC_EN   7:0
`define LCG_CFG_CASC_OR   15:8
`define LCG_CFG_USE_REG   23:16
`define LCG_CFG_CLK_SEL   31:24
`define LCG_SEL_W         7
`define LCG_SEL_KIND      3:0
`define LCG_SEL_IDX       6:4
`define LCG_MODE_CLR      2:0
`define LCG_MODE_CHIP_EN  3
`define LCG_MODE_INV      7:4
`define LCG_MODE_GDRV     10:8
`define LCG_STAT_Q        7:0
`define LCG_STAT_LINES    11:8
`define LCG_STAT_OUT      19:12

// ==========================================================================
// reset values and responses
`define LCG_LUT_RST       16'h0000
`define LCG_CFG_RST       32'h0000_0000
`define LCG_SEL_RST       32'h0000_0000
`define LCG_MODE_RST      32'h0000_0001
`define LCG_RESP_OKAY     2'h0
`define LCG_RESP_SLVERR   2'h2
`define LCG_TIE_HIGH      1'b1

`endif

// ---- hdl/lcg_logic_cell.sv ----
// one logic cell: lookup table, cascade stage and flip-flop
`timescale 1ns/1ps
module lcg_logic_cell (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic [15:0] lut_mask,
    input  wire logic [3:0]  data,
    input  wire logic        casc_in,
    input  wire logic        casc_en,
    input  wire logic        casc_or,
    input  wire logic        use_reg,
    input  wire logic        cap,
    input  wire logic        clr,
    input  wire logic        pre,
    output logic             lut_out,
    output logic             casc_out,
    output logic             cell_out,
    output logic             q
);
    import lcg_pkg::*;

    logic join_and;
    logic join_or;
    logic q_q;

    // ==========================================================================
    // table and cascade
    assign lut_out  = lut_mask[data]; // RULE1
    assign join_and = lut_out & casc_in; // RULE7
    assign join_or  = ~(~lut_out & ~casc_in); // RULE7
    assign casc_out = casc_en ? (casc_or ? join_or : join_and) : lut_out; // RULE8

    // ==========================================================================
    // flip-flop, clear beats preset beats capture
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            q_q <= 1'b0;
        end else if (clr) begin // RULE15
            q_q <= 1'b0;
        end else if (pre) begin
            q_q <= `LCG_TIE_HIGH; // RULE14
        end else if (cap) begin // RULE2
            q_q <= casc_out;
        end
    end

    assign q        = q_q;
    assign cell_out = use_reg ? q_q : casc_out;
endmodule : lcg_logic_cell

// ---- hdl/lcg_pkg.sv ----
// types shared by the logic cell group files
package lcg_pkg;
    typedef enum logic [3:0] {
        LCG_SRC_DED   = 4'h1,
        LCG_SRC_GLOB  = 4'h2,
        LCG_SRC_IO    = 4'h4,
        LCG_SRC_LOCAL = 4'h8
    } lcg_src_e;

    typedef enum logic [2:0] {
        LCG_MODE_NONE     = 3'h1,
        LCG_MODE_CLR_ONLY = 3'h2,
        LCG_MODE_PRE_CLR  = 3'h4
    } lcg_clr_mode_e;
endpackage : lcg_pkg
